// *** host_port_dev.sv ***
// Controller end of the generic asynchronous host bus port.
// Assumes host strobes are asynchronous; the interface resolves data.
// Operation
// - Decode 128 Kbyte window from seventeen addresses
// - Host places window at fixed physical range
// - Host assigns 64 to 512 KB block
// - Host asserts select on window access
// - Select comes from high address decode
// - Host drives read or write command
// - High-byte enable low for sixteen bits
// - Upper enable gates high byte both ways
// - Write taken while lower enable and select
// - Read drives data while read enable low
// - Wait low until data valid or taken
// - Wait held through refresh arbitration
// - Transfers timed by dedicated bus clock
// - Strobes asynchronous, synchronised internally
// - Seventeen address and sixteen data lines
// - Ignore bus status and direction inputs; busStatusN is latched with the straps and gates genericMode
// - Endian chosen by pin sampled at reset
// - Latch straps at reset release
// - Display memory at offsets up to 9FFFh
// - Registers at offsets FFE0h to FFFFh
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module host_port_dev (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  host_port_if.device     bus,
  input  wire logic [2:0] busSelectCfgPins,
  input  wire logic       endianCfgPin,
  input  wire logic       refreshReq,
  output logic            genericMode,
  output logic            bigEndian,
  output logic            accessError,
  output logic [15:0]     lastWriteData
);
  // Display memory is word organised; byte lanes are written separately.
  logic [7:0] memLo [0:20479];
  logic [7:0] memHi [0:20479];
  logic [7:0] regLo [0:31];
  logic [7:0] regHi [0:31];

  logic [3:0]  strobeSync;
  logic [2:0]  cfgSync;
  logic [1:0]  miscSync;
  logic        cfgDone_q;
  logic [1:0]  cfgCnt_q;
  logic        busClkSync;
  logic        busClkPrev_q;
  logic [16:0] addrLatch_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic        oe_q;
  logic        waitN_q;
  logic        isRead_q;
  logic [1:0]  arbCnt_q;
  host_port_pkg::dev_state_t state_q;

  wire logic cs  = ~strobeSync[0];
  wire logic rd  = ~strobeSync[1];
  wire logic wr  = ~strobeSync[2];
  wire logic ube = ~strobeSync[3];
  wire logic busClkRise = busClkSync && !busClkPrev_q;

  sync2 #(.W(4), .INIT(4'hf)) uStrobe (
    .clk (sys_clk),
    .rst (rst),
    .din ({bus.upperByteEnableN, bus.lowerWriteEnableN,
           bus.hostMemReadN, bus.hostCtrlSelectN}),
    .dout(strobeSync)
  );
  sync2 #(.W(3), .INIT(3'h0)) uCfg (
    .clk (sys_clk),
    .rst (rst),
    .din (busSelectCfgPins),
    .dout(cfgSync)
  );
  sync2 #(.W(2), .INIT(2'h0)) uMisc (
    .clk (sys_clk),
    .rst (rst),
    .din ({bus.busStatusN, endianCfgPin}),
    .dout(miscSync)
  );
  sync2 #(.W(1), .INIT(1'b0)) uBusClk (
    .clk (sys_clk),
    .rst (rst),
    .din (bus.busClock),
    .dout(busClkSync)
  );

  // The bus clock idles low in reset, so no false edge follows release.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busClkPrev_q <= 1'b0;
    end else begin
      busClkPrev_q <= busClkSync;
    end
  end

  // The strap synchronisers are cleared by reset, so the pin levels reach
  // their outputs only some edges after release; reading them earlier
  // would latch the reset value instead of the straps.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfgCnt_q    <= 2'h0;
      cfgDone_q   <= 1'b0;
      genericMode <= 1'b0;
      bigEndian   <= 1'b0;
    end else if (!cfgDone_q) begin
      if (cfgCnt_q == 2'(host_port_pkg::CFG_SETTLE)) begin
        cfgDone_q   <= 1'b1;
        genericMode <= (cfgSync == host_port_pkg::BUS_SEL_GENERIC)
                       && miscSync[1];
        bigEndian   <= miscSync[0];
      end else begin
        cfgCnt_q <= cfgCnt_q + 2'h1;
      end
    end
  end

  function automatic logic isMem(input logic [16:0] a);
    isMem = a[16:1] <= host_port_pkg::MEM_LAST[16:1];
  endfunction : isMem

  // The upper half of the window is unused, so registers are not aliased.
  function automatic logic isReg(input logic [16:0] a);
    isReg = (a >= host_port_pkg::REG_FIRST) &&
            (a <= host_port_pkg::REG_LAST);
  endfunction : isReg

  function automatic logic [15:0] laneOrder(input logic        be,
                                            input logic [15:0] w);
    laneOrder = be ? {w[7:0], w[15:8]} : w;
  endfunction : laneOrder

  // Address and data are stable once the synchronised strobe is seen.
  // Bus status and direction are not looked at during transfers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q     <= host_port_pkg::D_IDLE;
      addrLatch_q <= 17'h00000;
      wdata_q     <= 16'h0000;
      isRead_q    <= 1'b0;
      arbCnt_q    <= 2'h0;
      waitN_q     <= 1'b1;
    end else begin
      case (state_q)
        host_port_pkg::D_IDLE: begin
          if (cs && (rd || wr) && cfgDone_q) begin
            addrLatch_q <= bus.addrIn;
            wdata_q     <= bus.dataBus;
            isRead_q    <= rd;
            arbCnt_q    <= 2'(host_port_pkg::ARB_CYCLES);
            waitN_q     <= 1'b0;
            state_q     <= host_port_pkg::D_ARB;
          end
        end
        host_port_pkg::D_ARB: begin
          if (refreshReq) begin
            arbCnt_q <= 2'(host_port_pkg::ARB_CYCLES);
          end else if (arbCnt_q != 2'h0) begin
            arbCnt_q <= arbCnt_q - 2'h1;
          end else begin
            state_q <= host_port_pkg::D_XFER;
          end
        end
        host_port_pkg::D_XFER: begin
          state_q <= host_port_pkg::D_HOLD;
        end
        host_port_pkg::D_HOLD: begin
          // Wait ends on a bus clock edge, which also keeps read data on
          // the pins for at least one cycle before release.
          if (busClkRise) begin
            waitN_q <= 1'b1;
            state_q <= host_port_pkg::D_DONE;
          end
        end
        host_port_pkg::D_DONE: begin
          if (!cs || !(rd || wr)) begin
            state_q <= host_port_pkg::D_IDLE;
          end
        end
        default: state_q <= host_port_pkg::D_IDLE;
      endcase
    end
  end

  // Memory and register storage; no reset, contents are undefined.
  always_ff @(posedge sys_clk) begin
    if (state_q == host_port_pkg::D_XFER && !isRead_q) begin
      if (isMem(addrLatch_q)) begin
        memLo[addrLatch_q[15:1]] <= wdata_q[7:0];
        if (ube) begin
          memHi[addrLatch_q[15:1]] <= wdata_q[15:8];
        end
      end else if (isReg(addrLatch_q)) begin
        regLo[addrLatch_q[5:1]] <= wdata_q[7:0];
        if (ube) begin
          regHi[addrLatch_q[5:1]] <= wdata_q[15:8];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q       <= 16'h0000;
      oe_q          <= 1'b0;
      accessError   <= 1'b0;
      lastWriteData <= 16'h0000;
    end else begin
      if (state_q == host_port_pkg::D_XFER) begin
        accessError <= !isMem(addrLatch_q) && !isReg(addrLatch_q);
        if (isRead_q) begin
          oe_q <= 1'b1;
          if (isMem(addrLatch_q)) begin
            rdata_q <= laneOrder(bigEndian,
                                 {ube ? memHi[addrLatch_q[15:1]] : 8'h00,
                                  memLo[addrLatch_q[15:1]]});
          end else if (isReg(addrLatch_q)) begin
            rdata_q <= laneOrder(bigEndian,
                                 {ube ? regHi[addrLatch_q[5:1]] : 8'h00,
                                  regLo[addrLatch_q[5:1]]});
          end else begin
            rdata_q <= 16'h0000;
          end
        end else begin
          lastWriteData <= wdata_q;
        end
      end else if (state_q == host_port_pkg::D_IDLE || !rd) begin
        oe_q <= 1'b0;
      end
    end
  end

  // Read data is stored already in wire lane order, so the pins come
  // straight from a register and cannot glitch while the host samples.
  assign bus.devDataOut = rdata_q;
  assign bus.devDataOe  = oe_q;
  assign bus.waitN      = waitN_q;
endmodule : host_port_dev
`default_nettype wire

// *** host_port_host.sv ***
// Host end: APB slave registers drive one strobe transfer into the port.
// Assumes the controller end answers on waitN via host_port_if.
`timescale 1ns/1ps
`default_nettype none
module host_port_host (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  host_port_if.host        bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  logic [31:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic        read_q;
  logic        wide_q;
  logic        busy_q;
  logic        done_q;
  logic [2:0]  divCnt_q;
  logic        lclk_q;
  logic        waitSync;
  logic        oobErr_q;
  host_port_pkg::host_state_t state_q;

  sync2 #(.W(1), .INIT(1'b1)) uWait (
    .clk (sys_clk),
    .rst (rst),
    .din (bus.waitN),
    .dout(waitSync)
  );

  wire logic apbWr = psel && penable && pwrite;
  wire logic go    = apbWr && (paddr == host_port_pkg::APB_CTRL)
                     && pwdata[host_port_pkg::CTRL_GO] && !busy_q;

  // Bus clock toward the controller, divided from sys_clk.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divCnt_q <= 3'h0;
      lclk_q   <= 1'b0;
    end else if (divCnt_q == 3'(host_port_pkg::LCLK_HALF - 1)) begin
      divCnt_q <= 3'h0;
      lclk_q   <= ~lclk_q;
    end else begin
      divCnt_q <= divCnt_q + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_q   <= host_port_pkg::WIN_BASE;
      wdata_q  <= 16'h0000;
      read_q   <= 1'b0;
      wide_q   <= 1'b1;
      oobErr_q <= 1'b0;
    end else if (apbWr && !busy_q) begin
      case (paddr)
        host_port_pkg::APB_ADDR:  addr_q  <= pwdata;
        host_port_pkg::APB_WDATA: wdata_q <= pwdata[15:0];
        host_port_pkg::APB_CTRL: begin
          read_q   <= pwdata[host_port_pkg::CTRL_READ];
          wide_q   <= pwdata[host_port_pkg::CTRL_WIDE];
          oobErr_q <= !host_port_pkg::inWindow(addr_q);
        end
        default: ;
      endcase
    end
  end

  // An access outside the window is refused and never strobes the port.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= host_port_pkg::H_IDLE;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      case (state_q)
        host_port_pkg::H_IDLE: begin
          if (go && host_port_pkg::inWindow(addr_q)) begin
            busy_q  <= 1'b1;
            done_q  <= 1'b0;
            state_q <= host_port_pkg::H_STROBE;
          end
        end
        host_port_pkg::H_STROBE: begin
          // The controller needs a few edges before pulling wait low.
          if (waitSync && done_q) begin
            rdata_q <= bus.dataBus;
            state_q <= host_port_pkg::H_END;
          end else if (!waitSync) begin
            done_q <= 1'b1;
          end
        end
        host_port_pkg::H_END: begin
          busy_q  <= 1'b0;
          state_q <= host_port_pkg::H_IDLE;
        end
        default: state_q <= host_port_pkg::H_IDLE;
      endcase
    end
  end

  wire logic strobing = (state_q == host_port_pkg::H_STROBE);
  assign bus.addrIn            = addr_q[16:0];
  assign bus.hostCtrlSelectN   = !strobing;
  assign bus.hostMemReadN      = !(strobing && read_q);
  assign bus.lowerWriteEnableN = !(strobing && !read_q);
  assign bus.upperByteEnableN  = !wide_q;
  assign bus.busStatusN        = 1'b1;
  assign bus.readWriteDirN     = 1'b1;
  assign bus.busClock          = lclk_q;
  assign bus.hostDataOut       = wdata_q;
  assign bus.hostDataOe        = strobing && !read_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          host_port_pkg::APB_CTRL:
            prdata <= {29'h0, wide_q, read_q, busy_q};
          host_port_pkg::APB_ADDR:  prdata <= addr_q;
          host_port_pkg::APB_WDATA: prdata <= {16'h0, wdata_q};
          host_port_pkg::APB_RDATA: prdata <= {16'h0, rdata_q};
          host_port_pkg::APB_STATUS:
            prdata <= {30'h0, oobErr_q, busy_q};
          default: begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule : host_port_host
`default_nettype wire

// *** host_port_if.sv ***
// Interface joining the host end and the controller port end.
// Two-way data lines carry input, output and enable per end; the
// interface resolves the wire.
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
  logic [16:0] addrIn;
  logic        hostCtrlSelectN;
  logic        hostMemReadN;
  logic        lowerWriteEnableN;
  logic        upperByteEnableN;
  logic        busStatusN;
  logic        readWriteDirN;
  logic        busClock;
  logic [15:0] hostDataOut;
  logic        hostDataOe;
  logic [15:0] devDataOut;
  logic        devDataOe;
  logic [15:0] dataBus;
  logic        waitN;

  assign dataBus = devDataOe ? devDataOut :
                   (hostDataOe ? hostDataOut : 16'h0000);

  modport device (
    input  addrIn, hostCtrlSelectN, hostMemReadN, lowerWriteEnableN,
    input  upperByteEnableN, busStatusN, readWriteDirN, busClock, dataBus,
    output devDataOut, devDataOe, waitN
  );
  modport host (
    output addrIn, hostCtrlSelectN, hostMemReadN, lowerWriteEnableN,
    output upperByteEnableN, busStatusN, readWriteDirN, busClock,
    output hostDataOut, hostDataOe,
    input  dataBus, waitN
  );
endinterface : host_port_if
`default_nettype wire

// *** host_port_pkg.sv ***
// Package for the asynchronous host bus port and its host-side driver.
// Assumes both ends run on sys_clk at 10 MHz and meet in host_port_if.
package host_port_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;

  // Address window inside the controller.
  localparam logic [16:0] MEM_LAST  = 17'h09fff;
  localparam logic [16:0] REG_FIRST = 17'h0ffe0;
  localparam logic [16:0] REG_LAST  = 17'h0ffff;
  localparam int          REG_COUNT = 32;

  // Host-side placement of the controller window.
  localparam logic [31:0] WIN_BASE = 32'h133e0000;
  localparam logic [31:0] WIN_LAST = 32'h133fffff;

  // Configuration straps for the generic sixteen-bit bus.
  localparam logic [2:0] BUS_SEL_GENERIC = 3'h7;

  // Cycle counts.
  localparam int ARB_CYCLES    = 2;
  localparam int CFG_SETTLE    = 2;
  localparam int HOLD_CYCLES   = 1;
  localparam int LCLK_HALF     = 4;

  // Host APB register map, one word each.
  localparam logic [7:0] APB_CTRL   = 8'h00;
  localparam logic [7:0] APB_ADDR   = 8'h04;
  localparam logic [7:0] APB_WDATA  = 8'h08;
  localparam logic [7:0] APB_RDATA  = 8'h0c;
  localparam logic [7:0] APB_STATUS = 8'h10;

  // Control register fields.
  localparam int CTRL_GO   = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_WIDE = 2;

  typedef enum logic [2:0] {
    D_IDLE, D_ARB, D_XFER, D_HOLD, D_DONE
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE, H_STROBE, H_END
  } host_state_t;

  function automatic logic inWindow(input logic [31:0] a);
    inWindow = (a >= WIN_BASE) && (a <= WIN_LAST);
  endfunction : inWindow

endpackage : host_port_pkg

// *** host_port_props.sv ***
// Checker for the host port link, watching the interface signals only.
// Assumes one sys_clk domain and an asynchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module host_port_props (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [16:0] addrIn,
  input wire logic        hostCtrlSelectN,
  input wire logic        hostMemReadN,
  input wire logic        lowerWriteEnableN,
  input wire logic        busStatusN,
  input wire logic        readWriteDirN,
  input wire logic [15:0] devDataOut,
  input wire logic        devDataOe,
  input wire logic        waitN
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Two synchroniser stages hide a fresh select for two cycles.
  sequence syncGap;
    waitN [*2];
  endsequence
  // Arbitration keeps the host waiting for at least four cycles.
  sequence arbHold;
    !waitN [*4];
  endsequence

  AST_SYNC_GAP: assert property (
    $fell(hostCtrlSelectN) |-> syncGap) else $error("wait fell too early");
  AST_WAIT_START: assert property (
    $fell(hostCtrlSelectN) |-> ##[1:4] !waitN) else $error("no wait state");
  AST_ARB_HOLD: assert property (
    $fell(waitN) |-> arbHold) else $error("wait released too soon");
  AST_WAIT_END: assert property (
    $fell(waitN) |-> ##[4:40] waitN) else $error("wait never released");
  AST_WAIT_IN_CS: assert property (
    !waitN |-> !hostCtrlSelectN) else $error("wait low outside access");
  AST_READ_STABLE: assert property (
    ($rose(waitN) && !hostMemReadN) |-> devDataOe && $past(devDataOe) &&
    $stable(devDataOut)) else $error("read data not settled at release");
  AST_WRITE_NO_DRIVE: assert property (
    !lowerWriteEnableN |-> !devDataOe) else $error("device drove on write");
  AST_HOLD_REQ: assert property (
    (!hostCtrlSelectN && !waitN) |=> !hostCtrlSelectN && $stable(addrIn))
    else $error("request dropped while waiting");
  AST_ONE_DIR: assert property (
    hostMemReadN || lowerWriteEnableN) else $error("read and write together");
  AST_STROBE_CS: assert property (
    (!hostMemReadN || !lowerWriteEnableN) |-> !hostCtrlSelectN)
    else $error("strobe without select");
  AST_TIED_HIGH: assert property (
    busStatusN && readWriteDirN) else $error("status inputs not high");
endmodule : host_port_props
`default_nettype wire

// *** sync2.sv ***
// Two-flop synchroniser for a bundle of levels.
// Assumes inputs are asynchronous to clk; only the second stage is read.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= INIT;
      dout   <= INIT;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : sync2
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench: APB orders drive the host end across host_port_if.
// Assumes straps settle long before reset release; model is an array.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk;
  logic        rst;
  logic [2:0]  busSelectCfgPins;
  logic        endianCfgPin;
  logic        refreshReq = 1'b0;
  logic        genericMode;
  logic        bigEndian;
  logic        accessError;
  logic [15:0] lastWriteData;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          failures;
  int          samples_checked;
  int          cycles;
  logic [31:0] rng;
  logic [31:0] rd;
  logic        err;
  logic [15:0] mem [int];

  host_port_if link ();
  host_port_dev host_port_dev_i (.sys_clk(sys_clk), .rst(rst), .bus(link),
    .busSelectCfgPins(busSelectCfgPins), .endianCfgPin(endianCfgPin),
    .refreshReq(refreshReq), .genericMode(genericMode),
    .bigEndian(bigEndian), .accessError(accessError),
    .lastWriteData(lastWriteData));
  host_port_host host_port_host_i (.sys_clk(sys_clk), .rst(rst), .bus(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  host_port_props host_port_props_i (.sys_clk(sys_clk), .rst(rst),
    .addrIn(link.addrIn), .hostCtrlSelectN(link.hostCtrlSelectN),
    .hostMemReadN(link.hostMemReadN),
    .lowerWriteEnableN(link.lowerWriteEnableN),
    .busStatusN(link.busStatusN), .readWriteDirN(link.readWriteDirN),
    .devDataOut(link.devDataOut), .devDataOe(link.devDataOe),
    .waitN(link.waitN));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Short refresh bursts contend with host accesses now and then.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    refreshReq <= (cycles % 37) < 7;
    if (cycles == 20000) begin
      failures++;
      $display("[FAIL] cycles expected below 20000 seen %0d", cycles);
      conclude();
    end
  end

  function automatic logic [31:0] nextRnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : nextRnd

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic xfer(input logic [16:0] a, input logic [15:0] d,
                      input logic r, input logic wide);
    int n;
    apb(1'b1, host_port_pkg::APB_ADDR, host_port_pkg::WIN_BASE | {15'h0, a});
    apb(1'b1, host_port_pkg::APB_WDATA, {16'h0000, d});
    apb(1'b1, host_port_pkg::APB_CTRL, {29'h0, wide, r, 1'b1});
    n = 0;
    do begin
      apb(1'b0, host_port_pkg::APB_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    if (rd[0] !== 1'b0) begin
      failures++;
      $display("[FAIL] busy expected 0 seen %b", rd[0]);
    end
    apb(1'b0, host_port_pkg::APB_RDATA, 32'h0);
  endtask : xfer

  task automatic doReset(input logic [2:0] sel, input logic endian);
    rst <= 1'b1;
    busSelectCfgPins <= sel;
    endianCfgPin <= endian;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    mem.delete();
  endtask : doReset

  task automatic conclude();
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  initial begin
    logic [31:0] r;
    logic [16:0] a;
    logic [15:0] d;
    logic        ok;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    busSelectCfgPins = 3'h7;
    endianCfgPin = 1'b0;
    rng = 32'h00013f56;
    doReset(3'h7, 1'b0);
    check("genericMode", 32'h1, {31'h0, genericMode});
    check("bigEndian", 32'h0, {31'h0, bigEndian});
    for (int i = 0; i < 12; i++) begin
      r = nextRnd();
      case (i % 4)
        0: a = {r[16:1] % 16'h5000, 1'b0};
        1: a = 17'h0ffe0 + {12'h0, r[4:1], 1'b0};
        // The upper half of the window holds neither memory nor registers.
        3: a = {1'b1, r[15:1], 1'b0};
        default: a = 17'h0a000 + {1'b0, r[15:1] % 15'h2ff0, 1'b0};
      endcase
      ok = a <= host_port_pkg::MEM_LAST ||
           (a >= host_port_pkg::REG_FIRST && a <= host_port_pkg::REG_LAST);
      d = r[31:16];
      xfer(a, d, 1'b0, 1'b1);
      check("accessError", {31'h0, !ok}, {31'h0, accessError});
      if (ok) begin
        check("lastWriteData", {16'h0, d}, {16'h0, lastWriteData});
      end
      mem[a] = ok ? d : 16'h0000;
      // A byte write carries a changed upper byte that must be gated off.
      xfer(a, ~d, 1'b0, 1'b0);
      mem[a] = ok ? {mem[a][15:8], ~d[7:0]} : 16'h0000;
      xfer(a, 16'h0, 1'b1, 1'b1);
      check("readData", {16'h0, mem[a]}, {16'h0, rd[15:0]});
      xfer(a, 16'h0, 1'b1, 1'b0);
      check("byteRead", {24'h0, mem[a][7:0]}, {16'h0, rd[15:0]});
    end
    apb(1'b0, 8'h20, 32'h0);
    check("pslverr", 32'h1, {31'h0, err});
    apb(1'b1, host_port_pkg::APB_ADDR, 32'h133c0000);
    apb(1'b1, host_port_pkg::APB_CTRL, 32'h1);
    apb(1'b0, host_port_pkg::APB_STATUS, 32'h0);
    check("windowError", 32'h1, {31'h0, rd[1]});
    doReset(3'h7, 1'b1);
    check("bigEndian", 32'h1, {31'h0, bigEndian});
    d = 16'(nextRnd() >> 8);
    xfer(17'h00100, d, 1'b0, 1'b1);
    xfer(17'h00100, 16'h0, 1'b1, 1'b1);
    check("swapped", {16'h0, d[7:0], d[15:8]}, {16'h0, rd[15:0]});
    doReset(3'h5, 1'b0);
    check("genericMode", 32'h0, {31'h0, genericMode});
    conclude();
  end
endmodule : testbench
`default_nettype wire
